// ==== omt_pkg.sv ====
// Purpose: shared constants and types of the oam message transport
// Assumes: one 125 MHz clock, byte wide frame streams
// Notes: frame byte positions count from the first destination byte
package omt_pkg;
    // ****************************************
    // frame header constants
    // ****************************************
    localparam logic [47:0] OMT_DA = 48'h0180C2000002;
    localparam logic [15:0] OMT_ETYPE = 16'h8809;
    localparam logic [7:0] OMT_SUBTYPE = 8'h03;
    localparam logic [15:0] OMT_FLAGS_RST = 16'h0000;
    localparam logic [7:0] OMT_CODE_ORG = 8'hFE;
    // arbitrary organization identifier
    localparam logic [23:0] OMT_OUI_DEF = 24'h5A3C96;
    localparam logic [7:0] OMT_TL_VER = 8'h01;
    localparam logic [7:0] OMT_PDU_VER = 8'h01;
    localparam logic [7:0] OMT_TYP_PDU = 8'h00;
    localparam logic [7:0] OMT_TYP_ACK = 8'h01;
    localparam logic [7:0] OMT_RC_OK = 8'h00;
    localparam logic [7:0] OMT_RC_VER = 8'h01;
    localparam logic [7:0] OMT_RC_SEQ = 8'h02;
    localparam logic [7:0] OMT_RC_EXC = 8'h03;
    // ****************************************
    // byte positions
    // ****************************************
    localparam logic [8:0] OMT_POS_SA = 9'h006;
    localparam logic [8:0] OMT_POS_FLAGS = 9'h00F;
    localparam logic [8:0] OMT_POS_CODE = 9'h011;
    localparam logic [8:0] OMT_POS_OUI = 9'h012;
    localparam logic [8:0] OMT_POS_VER = 9'h015;
    localparam logic [8:0] OMT_POS_TYP = 9'h016;
    localparam logic [8:0] OMT_POS_SEQ = 9'h017;
    localparam logic [8:0] OMT_POS_TOT = 9'h019;
    localparam logic [8:0] OMT_POS_LEN = 9'h01B;
    localparam logic [8:0] OMT_HDR_LEN = 9'h01C;
    localparam logic [8:0] OMT_PDU_HDR_LEN = 9'h006;
    // ****************************************
    // timing and retry
    // ****************************************
    localparam logic [2:0] OMT_MAX_ATTEMPTS = 3'h4;
    localparam int OMT_CLK_NS = 8;
    localparam int OMT_ACK_TIMEOUT_NS = 1000000;
    localparam int OMT_ACK_TIMEOUT_CYC = OMT_ACK_TIMEOUT_NS / OMT_CLK_NS;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } omt_byte_t;
    typedef struct packed {
        logic first;
        logic [15:0] total;
        logic [15:0] msg_id;
        logic [15:0] opcode;
    } omt_frag_t;
    typedef struct packed {
        logic [15:0] msg_id;
        logic [15:0] opcode;
    } omt_msg_hdr_t;
    typedef struct packed {
        logic [7:0] typ;
        logic [15:0] seq;
        logic [15:0] total;
        logic [7:0] len;
    } omt_tl_hdr_t;
    typedef enum logic [1:0] {OMT_S_IDLE, OMT_S_SEND, OMT_S_WAIT} omt_snd_state_t;
endpackage

// ==== omt_transport.sv ====
// Purpose: oam message transport of the rf_interface_module, sender and receiver
// Assumes: frame streams on ref_clk_i, upper layer loads one fragment at a time
// Notes: first fragment data at most 249 bytes, acks take the link first

module omt_transport #(
    parameter int ACK_TIMEOUT_CYC = omt_pkg::OMT_ACK_TIMEOUT_CYC,
    parameter logic [23:0] OUI = omt_pkg::OMT_OUI_DEF
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [47:0] station_mac_i,
    input wire omt_pkg::omt_byte_t rx_i,
    output omt_pkg::omt_byte_t tx_o,
    input wire logic tx_ready_i,
    input wire omt_pkg::omt_byte_t frag_i,
    input wire omt_pkg::omt_frag_t frag_cmd_i,
    output logic frag_ready_o,
    output logic frag_acked_o,
    output logic chan_lost_o,
    output omt_pkg::omt_byte_t rcv_o,
    output omt_pkg::omt_msg_hdr_t msg_hdr_o
);
    import omt_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] hdr_byte(input logic [8:0] idx, input omt_tl_hdr_t h,
                                            input logic [47:0] mac);
        logic [223:0] hv;
        logic [223:0] sh;
        logic [8:0] rev;
        hv = {OMT_DA, mac, OMT_ETYPE, OMT_SUBTYPE, OMT_FLAGS_RST, OMT_CODE_ORG, OUI,
              OMT_TL_VER, h.typ, h.seq, h.total, h.len};
        rev = OMT_POS_LEN - idx;
        sh = hv >> {rev, 3'h0};
        return sh[7:0];
    endfunction

    function automatic logic fixed_pos(input logic [8:0] idx);
        return idx < OMT_POS_SA || (idx >= 9'h00C && idx < OMT_POS_FLAGS)
            || (idx >= OMT_POS_CODE && idx < OMT_POS_VER);
    endfunction

    // ****************************************
    // receive parser
    // ****************************************
    logic [8:0] rx_idx_r;
    logic rx_bad_r;
    omt_tl_hdr_t rx_hdr_r;
    logic [7:0] rx_ver_r;
    logic rx_pvbad_r;
    logic [7:0] rx_ak_r;
    logic [15:0] exp_seq_r;
    logic [15:0] last_seq_r;
    logic last_v_r;
    logic ack_pend_r;
    omt_tl_hdr_t ack_hdr_r;
    logic [7:0] ack_code_r;
    logic [8:0] rx_pidx;
    logic rx_pay;
    logic rx_dup;
    logic [7:0] rx_code;
    logic rx_fwd;
    logic rx_end;
    logic rx_pdu_end;
    logic rx_ack_end;
    logic [7:0] rx_akcode;

    assign rx_pidx = rx_idx_r - OMT_HDR_LEN;
    assign rx_pay = rx_i.valid && rx_idx_r >= OMT_HDR_LEN && !rx_bad_r;
    assign rx_dup = last_v_r && rx_hdr_r.seq == last_seq_r;
    assign rx_end = rx_i.valid && rx_i.last && !rx_bad_r && rx_idx_r >= OMT_HDR_LEN;
    assign rx_pdu_end = rx_end && rx_hdr_r.typ == OMT_TYP_PDU;
    assign rx_ack_end = rx_end && rx_hdr_r.typ == OMT_TYP_ACK;
    assign rx_akcode = (rx_idx_r == OMT_HDR_LEN) ? rx_i.data : rx_ak_r;

    always_comb begin
        if (rx_ver_r != OMT_TL_VER || rx_pvbad_r) begin
            rx_code = OMT_RC_VER;
        end else if (rx_dup) begin
            rx_code = OMT_RC_OK;
        end else if (rx_hdr_r.seq > rx_hdr_r.total) begin
            rx_code = OMT_RC_EXC;
        end else if (rx_hdr_r.seq == 16'h0001 || rx_hdr_r.seq == exp_seq_r) begin
            rx_code = OMT_RC_OK;
        end else begin
            rx_code = OMT_RC_SEQ;
        end
    end

    // only new, valid fragments pass data; first pdu header bytes stay here
    assign rx_fwd = rx_pay && rx_hdr_r.typ == OMT_TYP_PDU && rx_code == OMT_RC_OK
        && !rx_dup && rx_pidx < {1'b0, rx_hdr_r.len}
        && !(rx_hdr_r.seq == 16'h0001 && rx_pidx < OMT_PDU_HDR_LEN);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_idx_r <= 9'h000;
            rx_bad_r <= 1'b0;
        end else if (rx_i.valid) begin
            if (rx_i.last) begin
                rx_idx_r <= 9'h000;
                rx_bad_r <= 1'b0;
            end else begin
                if (rx_idx_r != 9'h1FF) begin
                    rx_idx_r <= rx_idx_r + 9'h001;
                end
                if (fixed_pos(rx_idx_r)
                    && rx_i.data != hdr_byte(rx_idx_r, '0, 48'h0)) begin
                    rx_bad_r <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_hdr_r <= '0;
            rx_ver_r <= 8'h00;
            rx_pvbad_r <= 1'b0;
            rx_ak_r <= 8'h00;
        end else if (rx_i.valid) begin
            case (rx_idx_r)
                OMT_POS_VER: rx_ver_r <= rx_i.data;
                OMT_POS_TYP: rx_hdr_r.typ <= rx_i.data;
                OMT_POS_SEQ: rx_hdr_r.seq[15:8] <= rx_i.data;
                OMT_POS_SEQ + 9'h001: rx_hdr_r.seq[7:0] <= rx_i.data;
                OMT_POS_TOT: rx_hdr_r.total[15:8] <= rx_i.data;
                OMT_POS_TOT + 9'h001: rx_hdr_r.total[7:0] <= rx_i.data;
                OMT_POS_LEN: rx_hdr_r.len <= rx_i.data;
                OMT_HDR_LEN: begin
                    rx_ak_r <= rx_i.data;
                    rx_pvbad_r <= rx_hdr_r.typ == OMT_TYP_PDU && rx_hdr_r.seq == 16'h0001
                        && rx_i.data != OMT_PDU_VER;
                end
                default: begin
                    if (rx_idx_r == 9'h000) begin
                        rx_pvbad_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // reassembly and upward delivery
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            exp_seq_r <= 16'h0001;
            last_seq_r <= 16'h0000;
            last_v_r <= 1'b0;
        end else if (rx_pdu_end && rx_code == OMT_RC_OK && !rx_dup) begin
            last_seq_r <= rx_hdr_r.seq;
            last_v_r <= 1'b1;
            if (rx_hdr_r.seq == rx_hdr_r.total) begin
                exp_seq_r <= 16'h0001;
            end else begin
                exp_seq_r <= rx_hdr_r.seq + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rcv_o <= '0;
        end else begin
            rcv_o.valid <= rx_fwd;
            rcv_o.data <= rx_i.data;
            rcv_o.last <= rx_fwd && rx_hdr_r.seq == rx_hdr_r.total
                && rx_pidx == {1'b0, rx_hdr_r.len} - 9'h001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            msg_hdr_o <= '0;
        end else if (rx_pay && rx_hdr_r.typ == OMT_TYP_PDU && rx_hdr_r.seq == 16'h0001
                     && rx_code == OMT_RC_OK && !rx_dup) begin
            case (rx_pidx)
                9'h002: msg_hdr_o.msg_id[15:8] <= rx_i.data;
                9'h003: msg_hdr_o.msg_id[7:0] <= rx_i.data;
                9'h004: msg_hdr_o.opcode[15:8] <= rx_i.data;
                9'h005: msg_hdr_o.opcode[7:0] <= rx_i.data;
                default: msg_hdr_o <= msg_hdr_o;
            endcase
        end
    end

    // ****************************************
    // acknowledgement queue
    // ****************************************
    logic tx_busy_r;
    logic ack_start;
    logic pdu_start;
    assign ack_start = !tx_busy_r && ack_pend_r;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack_pend_r <= 1'b0;
            ack_hdr_r <= '0;
            ack_code_r <= OMT_RC_OK;
        end else if (rx_pdu_end) begin
            ack_pend_r <= 1'b1;
            ack_hdr_r <= {OMT_TYP_ACK, rx_hdr_r.seq, rx_hdr_r.total, rx_hdr_r.len};
            ack_code_r <= rx_code;
        end else if (ack_start) begin
            ack_pend_r <= 1'b0;
        end
    end

    // ****************************************
    // sender
    // ****************************************
    logic [7:0] buf_r [0:255];
    logic [7:0] wr_cnt_r;
    logic [7:0] snd_cnt_r;
    omt_frag_t cmd_r;
    logic [15:0] snd_seq_r;
    omt_snd_state_t snd_state_r;
    logic [2:0] att_r;
    logic [31:0] tmr_r;
    logic ack_hit;
    logic tmo;
    logic retry;

    assign pdu_start = snd_state_r == OMT_S_SEND && !tx_busy_r && !ack_pend_r;
    assign ack_hit = rx_ack_end && rx_hdr_r.seq == snd_seq_r && snd_state_r == OMT_S_WAIT;
    assign tmo = snd_state_r == OMT_S_WAIT && !tx_busy_r
        && tmr_r == 32'(ACK_TIMEOUT_CYC - 1);
    assign retry = (ack_hit && rx_akcode != OMT_RC_OK) || (!ack_hit && tmo);

    always_ff @(posedge ref_clk_i) begin
        if (frag_ready_o && frag_i.valid) begin
            buf_r[wr_cnt_r] <= frag_i.data;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            snd_state_r <= OMT_S_IDLE;
            frag_ready_o <= 1'b0;
            frag_acked_o <= 1'b0;
            chan_lost_o <= 1'b0;
            wr_cnt_r <= 8'h00;
            snd_cnt_r <= 8'h00;
            cmd_r <= '0;
            snd_seq_r <= 16'h0000;
            att_r <= 3'h0;
            tmr_r <= 32'h0000_0000;
        end else begin
            frag_acked_o <= 1'b0;
            chan_lost_o <= 1'b0;
            case (snd_state_r)
                OMT_S_IDLE: begin
                    frag_ready_o <= 1'b1;
                    if (frag_ready_o && frag_i.valid) begin
                        wr_cnt_r <= wr_cnt_r + 8'h01;
                        if (frag_i.last) begin
                            snd_cnt_r <= wr_cnt_r + 8'h01;
                            wr_cnt_r <= 8'h00;
                            cmd_r <= frag_cmd_i;
                            snd_seq_r <= frag_cmd_i.first ? 16'h0001
                                : snd_seq_r + 16'h0001;
                            att_r <= 3'h0;
                            frag_ready_o <= 1'b0;
                            snd_state_r <= OMT_S_SEND;
                        end
                    end
                end
                OMT_S_SEND: begin
                    if (pdu_start) begin
                        att_r <= att_r + 3'h1;
                        tmr_r <= 32'h0000_0000;
                        snd_state_r <= OMT_S_WAIT;
                    end
                end
                OMT_S_WAIT: begin
                    if (!tx_busy_r) begin
                        tmr_r <= tmr_r + 32'h0000_0001;
                    end
                    if (ack_hit && rx_akcode == OMT_RC_OK) begin
                        frag_acked_o <= 1'b1;
                        snd_state_r <= OMT_S_IDLE;
                    end else if (retry) begin
                        if (att_r == OMT_MAX_ATTEMPTS) begin
                            chan_lost_o <= 1'b1;
                            snd_state_r <= OMT_S_IDLE;
                        end else begin
                            snd_state_r <= OMT_S_SEND;
                        end
                    end
                end
                default: snd_state_r <= OMT_S_IDLE;
            endcase
        end
    end

    // ****************************************
    // transmit engine
    // ****************************************
    logic tx_ack_r;
    logic [8:0] tx_idx_r;
    omt_tl_hdr_t tx_hdr_r;
    logic [7:0] tx_code_r;
    logic [8:0] tx_pidx;
    logic [8:0] tx_last_idx;
    logic tx_adv;
    logic [7:0] tx_byte;
    logic [7:0] pdu_byte;
    logic [7:0] boff;

    assign tx_pidx = tx_idx_r - OMT_HDR_LEN;
    assign tx_last_idx = tx_ack_r ? OMT_HDR_LEN
        : OMT_HDR_LEN + {1'b0, tx_hdr_r.len} - 9'h001;
    assign tx_adv = tx_busy_r && (!tx_o.valid || tx_ready_i);

    always_comb begin
        boff = tx_pidx[7:0];
        pdu_byte = 8'h00;
        if (tx_hdr_r.seq == 16'h0001) begin
            boff = tx_pidx[7:0] - OMT_PDU_HDR_LEN[7:0];
            case (tx_pidx)
                9'h000: pdu_byte = OMT_PDU_VER;
                9'h001: pdu_byte = 8'h00;
                9'h002: pdu_byte = cmd_r.msg_id[15:8];
                9'h003: pdu_byte = cmd_r.msg_id[7:0];
                9'h004: pdu_byte = cmd_r.opcode[15:8];
                9'h005: pdu_byte = cmd_r.opcode[7:0];
                default: pdu_byte = buf_r[boff];
            endcase
        end else begin
            pdu_byte = buf_r[boff];
        end
        if (tx_idx_r < OMT_HDR_LEN) begin
            tx_byte = hdr_byte(tx_idx_r, tx_hdr_r, station_mac_i);
        end else if (tx_ack_r) begin
            tx_byte = tx_code_r;
        end else begin
            tx_byte = pdu_byte;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_busy_r <= 1'b0;
            tx_ack_r <= 1'b0;
            tx_idx_r <= 9'h000;
            tx_hdr_r <= '0;
            tx_code_r <= 8'h00;
            tx_o <= '0;
        end else begin
            if (ack_start) begin
                tx_busy_r <= 1'b1;
                tx_ack_r <= 1'b1;
                tx_idx_r <= 9'h000;
                tx_hdr_r <= ack_hdr_r;
                tx_code_r <= ack_code_r;
            end else if (pdu_start) begin
                tx_busy_r <= 1'b1;
                tx_ack_r <= 1'b0;
                tx_idx_r <= 9'h000;
                tx_hdr_r <= {OMT_TYP_PDU, snd_seq_r, cmd_r.total, snd_seq_r == 16'h0001
                    ? snd_cnt_r + OMT_PDU_HDR_LEN[7:0] : snd_cnt_r};
            end else if (tx_adv) begin
                tx_idx_r <= tx_idx_r + 9'h001;
                if (tx_idx_r == tx_last_idx) begin
                    tx_busy_r <= 1'b0;
                end
            end
            if (tx_adv) begin
                tx_o <= {1'b1, tx_idx_r == tx_last_idx, tx_byte};
            end else if (tx_ready_i) begin
                tx_o.valid <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_pdu_in_ok;
        rx_pdu_end && rx_code == OMT_RC_OK && !rx_dup;
    endsequence
    sequence s_ack_queued;
        ack_pend_r && ack_hdr_r.typ == OMT_TYP_ACK;
    endsequence

    chk_ack_answer: assert property (rx_pdu_end |=> s_ack_queued)
        else $error("pdu frame not answered");
    chk_ack_copy: assert property (ack_start |=> tx_hdr_r.seq == $past(ack_hdr_r.seq)
        && tx_hdr_r.typ == OMT_TYP_ACK && tx_code_r == $past(ack_code_r))
        else $error("ack header not copied");
    chk_dup_kept_once: assert property (rx_pdu_end && rx_dup && rx_ver_r == OMT_TL_VER
        && !rx_pvbad_r |=> ack_code_r == OMT_RC_OK && $stable(exp_seq_r))
        else $error("duplicate handled wrong");
    chk_version_code: assert property (rx_pdu_end && rx_ver_r != OMT_TL_VER
        |=> ack_code_r == OMT_RC_VER)
        else $error("bad version not flagged");
    chk_one_outstanding: assert property (snd_state_r == OMT_S_WAIT && !ack_hit
        && !tmo |=> snd_state_r == OMT_S_WAIT && !frag_ready_o)
        else $error("sender left wait without answer");
    chk_seq_ascend: assert property ($changed(snd_seq_r) |-> snd_seq_r == 16'h0001
        || snd_seq_r == $past(snd_seq_r) + 16'h0001)
        else $error("sequence not ascending");
    chk_retry_limit: assert property (chan_lost_o |-> snd_state_r == OMT_S_IDLE
        && $past(att_r) == OMT_MAX_ATTEMPTS)
        else $error("lost raised at wrong attempt");
    chk_timeout_retx: assert property (tmo && !ack_hit && att_r < OMT_MAX_ATTEMPTS
        |=> snd_state_r == OMT_S_SEND ##[0:200] pdu_start)
        else $error("no retransmit after timeout");
    chk_code_byte: assert property (tx_adv && tx_idx_r == OMT_POS_CODE
        |=> tx_o.valid && tx_o.data == OMT_CODE_ORG)
        else $error("code byte wrong");
    chk_msg_done: assert property (rcv_o.last |-> $past(rx_code) == OMT_RC_OK
        && !$past(rx_dup) && $past(rx_hdr_r.seq) == $past(rx_hdr_r.total))
        else $error("message closed early");
    chk_msg_restart: assert property ((s_pdu_in_ok ##0 rx_hdr_r.seq == rx_hdr_r.total)
        |=> exp_seq_r == 16'h0001)
        else $error("sequence not restarted");
endmodule

// ==== omt_far_end.sv ====
// Purpose: far end model, sends frames to the block and collects what it sends
// Assumes: byte stream on the block clock
// Notes: slow makes the sink take a byte only every other cycle
module omt_far_end (
    input wire logic ref_clk_i,
    input wire omt_pkg::omt_byte_t tx_i,
    output logic tx_ready_o,
    output omt_pkg::omt_byte_t rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import omt_pkg::*;
    logic slow = 1'b0;
    logic [7:0] got[$];
    initial begin
        tx_ready_o = 1'b1;
        rx_o = '0;
    end
    always @(posedge ref_clk_i) begin
        if (tx_i.valid && tx_ready_o) got.push_back(tx_i.data);
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    end
    // whole frame at once, the idle line shows the inverse of the last byte
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge ref_clk_i);
            rx_o <= '{1'b1, i == b.size() - 1, b[i]};
        end
        @(posedge ref_clk_i);
        rx_o <= '{1'b0, 1'b0, ~b[b.size() - 1]};
    endtask
endmodule

// ==== oam_message_transport_tb.sv ====
// Purpose: self-checking bench of the oam message transport
// Assumes: ack timeout shortened to 200 cycles
// Notes: the far end model collects every byte the block sends
`define FE u_omt_far_end
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module oam_message_transport_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import omt_pkg::*;
    typedef logic [7:0] omt_q_t[$];
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    omt_byte_t rx_i, tx_o, rcv_o;
    omt_byte_t frag_i = '0;
    omt_frag_t frag_cmd_i = '0;
    omt_msg_hdr_t msg_hdr_o;
    logic tx_ready_i, frag_ready_o, frag_acked_o, chan_lost_o;
    int n_fail = 0, cmp_count = 0, cyc = 0, rcv_n = 0, ack_n = 0, lost_n = 0;
    logic [7:0] rcv_last = '0;
    logic rcv_end = 1'b0;
    always #4 ref_clk_i = ~ref_clk_i;
    omt_transport #(.ACK_TIMEOUT_CYC(200)) u_omt_transport (.ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i), .station_mac_i(48'h02AA55AA5501), .rx_i(rx_i), .tx_o(tx_o),
        .tx_ready_i(tx_ready_i), .frag_i(frag_i), .frag_cmd_i(frag_cmd_i),
        .frag_ready_o(frag_ready_o), .frag_acked_o(frag_acked_o), .chan_lost_o(chan_lost_o),
        .rcv_o(rcv_o), .msg_hdr_o(msg_hdr_o));
    omt_far_end u_omt_far_end (.ref_clk_i(ref_clk_i), .tx_i(tx_o), .tx_ready_o(tx_ready_i),
        .rx_o(rx_i));
    // ****************************************
    // monitors and timeout
    // ****************************************
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            summarize();
        end
        if (rcv_o.valid) rcv_n <= rcv_n + 1;
        if (rcv_o.valid) rcv_last <= rcv_o.data;
        if (rcv_o.valid && rcv_o.last) rcv_end <= 1'b1;
        if (frag_acked_o) ack_n <= ack_n + 1;
        if (chan_lost_o) lost_n <= lost_n + 1;
    end
    function automatic omt_q_t frm(logic [7:0] v, t, logic [15:0] s, n, logic [7:0] l, omt_q_t p);
        return {8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h02, 8'h02, 8'hAA, 8'h55, 8'hAA, 8'h55,
            8'h01, 8'h88, 8'h09, 8'h03, 8'h00, 8'h00, 8'hFE, OMT_OUI_DEF[23:16],
            OMT_OUI_DEF[15:8], OMT_OUI_DEF[7:0], v, t, s[15:8], s[7:0], n[15:8], n[7:0], l, p};
    endfunction
    task automatic wait_got(int n);
        for (int k = 0; k < 1500 && `FE.got.size() < n; k++) @(posedge ref_clk_i);
        `CHK(`FE.got.size() >= n, 1'b1)
    endtask
    task automatic rx_pdu(logic [7:0] v, logic [15:0] s, n, omt_q_t p, logic [7:0] rc);
        logic [7:0] g[$];
        `FE.got.delete();
        `FE.send(frm(v, 8'h00, s, n, 8'(p.size()), p));
        wait_got(29);
        g = `FE.got;
        `CHK({g[0], g[12], g[17], g[22]}, {8'h01, 8'h88, 8'hFE, 8'h01})
        `CHK({g[23], g[24], g[25], g[26]}, {s, n})
        `CHK({g[27], g[28]}, {8'(p.size()), rc})
    endtask
    task automatic rx_bad(int pos);
        omt_q_t f;
        f = frm(8'h01, 8'h00, 16'h1, 16'h1, 8'h01, {8'h5D});
        f[pos] = ~f[pos];
        `FE.got.delete();
        `FE.send(f);
        repeat (40) @(posedge ref_clk_i);
        `CHK(`FE.got.size(), 0)
    endtask
    task automatic load(logic f, logic [7:0] d);
        while (frag_ready_o !== 1'b1) @(negedge ref_clk_i);
        @(posedge ref_clk_i);
        frag_i <= '{1'b1, 1'b1, d};
        frag_cmd_i <= '{f, 16'h0002, 16'h1234, 16'hABCD};
        @(posedge ref_clk_i);
        frag_i <= '0;
    endtask
    task automatic tx_pdu(logic [15:0] s, omt_q_t p);
        logic [7:0] g[$];
        wait_got(28 + p.size());
        g = `FE.got;
        `CHK({g[5], g[12], g[13], g[14]}, {8'h02, 8'h88, 8'h09, 8'h03})
        `CHK({g[17], g[21], g[22], g[23], g[24]}, {8'hFE, 8'h01, 8'h00, s})
        `CHK({g[25], g[26]}, 16'h0002)
        `CHK({g[18], g[19], g[20], g[27]}, {OMT_OUI_DEF, 8'(p.size())})
        foreach (p[i]) `CHK(g[28 + i], p[i])
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        omt_q_t p1;
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        p1 = {8'h01, 8'h00, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'h5A};
        rx_pdu(8'h01, 16'h1, 16'h3, p1, OMT_RC_OK);
        `CHK(msg_hdr_o, 32'h1234ABCD)
        rx_pdu(8'h01, 16'h1, 16'h3, p1, OMT_RC_OK);
        rx_pdu(8'h01, 16'h3, 16'h3, {8'h5B}, OMT_RC_SEQ);
        rx_pdu(8'h01, 16'h4, 16'h3, {8'h5B}, OMT_RC_EXC);
        rx_pdu(8'h01, 16'h2, 16'h3, {8'h5B}, OMT_RC_OK);
        rx_pdu(8'h02, 16'h3, 16'h3, {8'h5C}, OMT_RC_VER);
        `CHK(rcv_end, 1'b0)
        rx_pdu(8'h01, 16'h3, 16'h3, {8'h5C}, OMT_RC_OK);
        repeat (2) @(posedge ref_clk_i);
        `CHK({rcv_n[7:0], rcv_last, rcv_end}, {8'h03, 8'h5C, 1'b1})
        rx_bad(17);
        rx_bad(19);
        `FE.slow = 1'b1;
        p1[6] = 8'h77;
        `FE.got.delete();
        load(1'b1, 8'h77);
        tx_pdu(16'h1, p1);
        `CHK(frag_ready_o, 1'b0)
        `FE.got.delete();
        `FE.send(frm(8'h01, 8'h01, 16'h1, 16'h2, 8'h07, {OMT_RC_SEQ}));
        tx_pdu(16'h1, p1);
        `FE.send(frm(8'h01, 8'h01, 16'h1, 16'h2, 8'h07, {OMT_RC_OK}));
        repeat (3) @(posedge ref_clk_i);
        `CHK(ack_n[7:0], 8'h01)
        `FE.slow = 1'b0;
        `FE.got.delete();
        load(1'b0, 8'h66);
        tx_pdu(16'h2, {8'h66});
        wait_got(116);
        repeat (205) @(posedge ref_clk_i);
        `CHK({lost_n[7:0], `FE.got[110], `FE.got[111]}, {8'h01, 8'h00, 8'h02})
        `CHK(`FE.got.size(), 116)
        summarize();
    end
endmodule
